// >>> rtl/hall_i2c_target.sv
// Operation
// - answer at 56h strap low, 57h high
// - output is field*511/range plus 511
// - range register at 0Bh, four ranges
// - codes 0,1,2 give 50, 25, 12.5 mT
// - config bit 1 selects magnet polarity
// - config bit 3 selects slow or fast
// - config bit 0 powers the sensor down
// - 00h low bits, 01h high, flag, parity
// - defaults usable, configuration optional
`timescale 1ns/1ps
module hall_i2c_target #(
    parameter int SETTLE_CYCLES = hall_pkg::SETTLE_CYC
) (
    // system
    input wire logic MCLK,
    input wire logic RESET_N,
    // i2c pins
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // address strap
    input wire logic ADDRESS_JUMPER,
    // hall front end, own clock
    input wire logic FE_CLK,
    input wire logic FE_VALID,
    input wire logic signed [15:0] FE_FIELD,
    output logic FE_POWER_DOWN,
    output logic FE_FAST
);
    initial
    begin
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << 20))
            $error("SETTLE_CYCLES out of range");
    end

    // pin synchronisers
    logic [1:0] scl_q_r, sda_q_r, strap_q_r;
    logic scl_p_r, sda_p_r;
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            scl_q_r <= 2'h3;
            sda_q_r <= 2'h3;
            strap_q_r <= 2'h0;
            scl_p_r <= 1'b1;
            sda_p_r <= 1'b1;
        end
        else
        begin
            scl_q_r <= {scl_q_r[0], SCL_IN};
            sda_q_r <= {sda_q_r[0], SDA_IN};
            strap_q_r <= {strap_q_r[0], ADDRESS_JUMPER};
            scl_p_r <= scl_q_r[1];
            sda_p_r <= sda_q_r[1];
        end
    end
    wire scl_s = scl_q_r[1];
    wire sda_s = sda_q_r[1];
    hall_pkg::bus_ev_t ev;
    assign ev.start = scl_s & scl_p_r & sda_p_r & ~sda_s;
    assign ev.stop = scl_s & scl_p_r & ~sda_p_r & sda_s;
    assign ev.rise = scl_s & ~scl_p_r;
    assign ev.fall = ~scl_s & scl_p_r;

    logic [19:0] settle_r;
    logic ready_r;
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            settle_r <= 20'h00000;
            ready_r <= 1'b0;
        end
        else if (!ready_r)
        begin
            settle_r <= settle_r + 20'h00001;
            ready_r <= (settle_r == 20'(SETTLE_CYCLES - 1));
        end
    end

    // strap picks the address; synchronised and followed every cycle after release, not latched at reset
    wire [6:0] dev_addr = strap_q_r[1] ? hall_pkg::ADDR_STRAP_HI : hall_pkg::ADDR_STRAP_LO;

    // registers and protocol state
    hall_pkg::i2c_st_t st_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r, ptr_r, cfg_r;
    logic [1:0] range_r;
    logic rw_r, first_r, oe_r;
    logic [9:0] pos_r;
    logic flag_r;
    wire [7:0] rd_data;
    wire byte_done = ev.fall & (bit_r == 4'h8);
    wire addr_hit = (sh_r[7:1] == dev_addr) & ready_r;
    wire wr_cfg = (st_r == hall_pkg::ST_RX) & byte_done & ~first_r & (ptr_r == hall_pkg::REG_CFG);
    wire wr_range = (st_r == hall_pkg::ST_RX) & byte_done & ~first_r & (ptr_r == hall_pkg::REG_RANGE);

    wire parity = ^{flag_r, pos_r};
    wire [7:0] hi_byte = {4'h0, parity, flag_r, pos_r[9:8]};
    assign rd_data = (ptr_r == hall_pkg::REG_POS_LO) ? pos_r[7:0] :
                     (ptr_r == hall_pkg::REG_POS_HI) ? hi_byte :
                     (ptr_r == hall_pkg::REG_CFG) ? cfg_r :
                     (ptr_r == hall_pkg::REG_RANGE) ? {6'h00, range_r} : 8'h00;

    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            st_r <= hall_pkg::ST_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            oe_r <= 1'b0;
        end
        else if (ev.start)
        begin
            st_r <= hall_pkg::ST_ADDR;
            bit_r <= 4'h0;
            oe_r <= 1'b0;
        end
        else if (ev.stop)
        begin
            st_r <= hall_pkg::ST_IDLE;
            oe_r <= 1'b0;
        end
        else
        begin
            case (st_r)
                hall_pkg::ST_ADDR, hall_pkg::ST_RX:
                begin
                    if (ev.rise && bit_r != 4'h8)
                    begin
                        sh_r <= {sh_r[6:0], sda_s};
                        bit_r <= bit_r + 4'h1;
                    end
                    else if (byte_done && st_r == hall_pkg::ST_ADDR)
                    begin
                        oe_r <= addr_hit;
                        rw_r <= sh_r[0];
                        first_r <= ~sh_r[0];
                        st_r <= addr_hit ? hall_pkg::ST_ACK : hall_pkg::ST_IDLE;
                    end
                    else if (byte_done)
                    begin
                        if (first_r)
                            ptr_r <= sh_r;
                        else
                            ptr_r <= ptr_r + 8'h01;
                        first_r <= 1'b0;
                        oe_r <= 1'b1;
                        st_r <= hall_pkg::ST_ACK;
                    end
                end
                hall_pkg::ST_ACK:
                begin
                    if (ev.fall)
                    begin
                        bit_r <= 4'h0;
                        sh_r <= rd_data;
                        oe_r <= rw_r & ~rd_data[7];
                        st_r <= rw_r ? hall_pkg::ST_TX : hall_pkg::ST_RX;
                    end
                end
                hall_pkg::ST_TX:
                begin
                    if (ev.rise)
                        bit_r <= bit_r + 4'h1;
                    else if (byte_done)
                    begin
                        oe_r <= 1'b0;
                        ptr_r <= ptr_r + 8'h01;
                        st_r <= hall_pkg::ST_TXACK;
                    end
                    else if (ev.fall)
                    begin
                        sh_r <= {sh_r[6:0], 1'b0};
                        oe_r <= ~sh_r[6];
                    end
                end
                hall_pkg::ST_TXACK:
                begin
                    // a nack ends the read, the host then stops
                    if (ev.rise && sda_s)
                        st_r <= hall_pkg::ST_IDLE;
                    else if (ev.fall)
                    begin
                        bit_r <= 4'h0;
                        sh_r <= rd_data;
                        oe_r <= ~rd_data[7];
                        st_r <= hall_pkg::ST_TX;
                    end
                end
                default:
                    oe_r <= 1'b0;
            endcase
        end
    end
    assign SDA_OUT = 1'b0;
    assign SDA_OE = oe_r;

    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cfg_r <= hall_pkg::CFG_RESET;
            range_r <= hall_pkg::RANGE_RESET;
        end
        else
        begin
            if (wr_cfg)
                cfg_r <= sh_r & hall_pkg::CFG_MASK;
            if (wr_range)
                range_r <= sh_r[1:0];
        end
    end
    hall_pkg::cfg_t cfg;
    assign cfg.pd = cfg_r[hall_pkg::CFG_PD_BIT];
    assign cfg.pol = cfg_r[hall_pkg::CFG_POL_BIT];
    assign cfg.fast = cfg_r[hall_pkg::CFG_FAST_BIT];

    // front end domain: level syncs in, handshake word out
    logic [1:0] fe_pd_q_r, fe_fast_q_r, fe_ack_q_r;
    logic fe_tgl_r;
    logic ack_tgl_r;
    logic signed [15:0] fe_word_r;
    wire fe_free = (fe_ack_q_r[1] == fe_tgl_r);
    wire fe_take = FE_VALID & fe_free & ~fe_pd_q_r[1];
    always_ff @(posedge FE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            fe_pd_q_r <= 2'h0;
            fe_fast_q_r <= 2'h0;
            fe_ack_q_r <= 2'h0;
            fe_tgl_r <= 1'b0;
            fe_word_r <= 16'h0000;
        end
        else
        begin
            fe_pd_q_r <= {fe_pd_q_r[0], cfg.pd};
            fe_fast_q_r <= {fe_fast_q_r[0], cfg.fast};
            fe_ack_q_r <= {fe_ack_q_r[0], ack_tgl_r};
            if (fe_take)
            begin
                fe_word_r <= FE_FIELD;
                fe_tgl_r <= ~fe_tgl_r;
            end
        end
    end
    assign FE_POWER_DOWN = fe_pd_q_r[1];
    assign FE_FAST = fe_fast_q_r[1];

    // word stays put until the acknowledge returns, so one capture is safe
    logic [2:0] tgl_q_r;
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            tgl_q_r <= 3'h0;
            ack_tgl_r <= 1'b0;
        end
        else
        begin
            tgl_q_r <= {tgl_q_r[1:0], fe_tgl_r};
            ack_tgl_r <= tgl_q_r[1];
        end
    end
    wire upd = tgl_q_r[2] ^ tgl_q_r[1];

    wire [9:0] div = (range_r == 2'h0) ? hall_pkg::RANGE_0 :
                     (range_r == 2'h1) ? hall_pkg::RANGE_1 :
                     (range_r == 2'h2) ? hall_pkg::RANGE_2 : hall_pkg::RANGE_3;
    wire signed [16:0] mag = cfg.pol ? -17'(fe_word_r) : 17'(fe_word_r);
    wire signed [26:0] prod = 27'(mag) * 27'sd511;
    wire signed [26:0] quot = prod / $signed({17'h00000, div});
    wire signed [26:0] val = quot + $signed(27'(hall_pkg::POS_MID));
    // clamp instead of wrapping
    // signed compare, else a negative value would read as over range
    wire over = (val > $signed(27'(hall_pkg::POS_MAX)));
    wire under = (val < 27'sd0);
    wire [9:0] sat = over ? hall_pkg::POS_MAX : under ? 10'h000 : val[9:0];
    // slow mode averages with the previous value, trading lag for noise
    wire [10:0] sum = {1'b0, pos_r} + {1'b0, sat};
    wire [9:0] avg = sum[10:1];
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            pos_r <= hall_pkg::POS_RESET;
            flag_r <= 1'b0;
        end
        else if (upd)
        begin
            pos_r <= cfg.fast ? sat : avg;
            flag_r <= over | under;
        end
    end

    property p_addr_ack;
        @(posedge MCLK) disable iff (!RESET_N)
        (st_r == hall_pkg::ST_ADDR && byte_done && !ev.start && !ev.stop) |=> (SDA_OE == $past(addr_hit));
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
    property p_settle;
        @(posedge MCLK) disable iff (!RESET_N) !ready_r |-> !SDA_OE;
    endproperty
    a_settle: assert property (p_settle) else $error("ack during settle");
    property p_mid;
        @(posedge MCLK) disable iff (!RESET_N) (upd && cfg.fast && fe_word_r == 16'h0000) |=> pos_r == 10'h1FF;
    endproperty
    a_mid: assert property (p_mid) else $error("zero field not mid-scale");
    property p_range_wr;
        @(posedge MCLK) disable iff (!RESET_N) wr_range |=> range_r == $past(sh_r[1:0]);
    endproperty
    a_range_wr: assert property (p_range_wr) else $error("range write lost");
    property p_decode;
        @(posedge MCLK) disable iff (!RESET_N) range_r == 2'h1 |-> div == 10'h0FA;
    endproperty
    a_decode: assert property (p_decode) else $error("range decode wrong");
    property p_pol;
        @(posedge MCLK) disable iff (!RESET_N) cfg_r[1] |-> mag == -17'(fe_word_r);
    endproperty
    a_pol: assert property (p_pol) else $error("polarity not applied");
    property p_slow;
        @(posedge MCLK) disable iff (!RESET_N) (upd && !cfg_r[3]) |=> pos_r == $past(avg);
    endproperty
    a_slow: assert property (p_slow) else $error("slow mode not averaged");
    property p_pd;
        @(posedge FE_CLK) disable iff (!RESET_N) FE_POWER_DOWN |=> $stable(fe_tgl_r);
    endproperty
    a_pd: assert property (p_pd) else $error("sample taken in power-down");
    property p_hi;
        @(posedge MCLK) disable iff (!RESET_N) ptr_r == 8'h01 |-> rd_data[1:0] == pos_r[9:8] && rd_data[3] == parity;
    endproperty
    a_hi: assert property (p_hi) else $error("high byte wrong");
    property p_dflt;
        @(posedge MCLK) disable iff (!RESET_N) !ready_r |-> cfg_r == 8'h00 && range_r == 2'h0;
    endproperty
    a_dflt: assert property (p_dflt) else $error("defaults changed");
    property p_sat;
        @(posedge MCLK) disable iff (!RESET_N) (upd && cfg.fast && over) |=> pos_r == 10'h3FF && flag_r;
    endproperty
    a_sat: assert property (p_sat) else $error("no saturation");
    c_read: cover property (@(posedge MCLK) disable iff (!RESET_N) st_r == hall_pkg::ST_TXACK);
    c_range: cover property (@(posedge MCLK) disable iff (!RESET_N) wr_range);
    c_clip: cover property (@(posedge MCLK) disable iff (!RESET_N) upd && under);
endmodule

// >>> rtl/hall_pkg.sv
package hall_pkg;
    // bus addresses selected by the strap
    localparam logic [6:0] ADDR_STRAP_LO = 7'h56;
    localparam logic [6:0] ADDR_STRAP_HI = 7'h57;
    // register offsets
    localparam logic [7:0] REG_POS_LO = 8'h00;
    localparam logic [7:0] REG_POS_HI = 8'h01;
    localparam logic [7:0] REG_CFG = 8'h02;
    localparam logic [7:0] REG_RANGE = 8'h0B;
    // config fields and reset values
    localparam int CFG_PD_BIT = 0;
    localparam int CFG_POL_BIT = 1;
    localparam int CFG_FAST_BIT = 3;
    localparam logic [7:0] CFG_MASK = 8'h0B;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [1:0] RANGE_RESET = 2'h0;
    // high byte layout
    localparam int STAT_FLAG_BIT = 2;
    localparam int STAT_PAR_BIT = 3;
    // full-scale ranges in 0.1 mT steps: 50, 25, 12.5, 18.5 mT
    localparam logic [9:0] RANGE_0 = 10'h1F4;
    localparam logic [9:0] RANGE_1 = 10'h0FA;
    localparam logic [9:0] RANGE_2 = 10'h07D;
    localparam logic [9:0] RANGE_3 = 10'h0B9;
    localparam logic [9:0] POS_MID = 10'h1FF;
    localparam logic [9:0] POS_MAX = 10'h3FF;
    localparam logic [9:0] POS_RESET = 10'h1FF;
    // settling time after power-up
    localparam int SETTLE_US = 1500;
    localparam int MCLK_MHZ = 25;
    localparam int SETTLE_CYC = SETTLE_US * MCLK_MHZ;

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TXACK} i2c_st_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } bus_ev_t;

    typedef struct packed {
        logic fast;
        logic pol;
        logic pd;
    } cfg_t;
endpackage

// >>> verif/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model (
    // clock
    input wire logic clk,
    // bus
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // each scl phase is well over 4 mclk so the target's synchroniser keeps up
    task automatic bit_slot(input logic b, output logic s);
        tick(1);
        sda_pull <= ~b;
        tick(5);
        scl <= 1'b1;
        tick(5);
        s = sda;
        tick(5);
        scl <= 1'b0;
    endtask
    // also serves as repeated start: release sda while scl is low first
    task automatic start();
        tick(1);
        sda_pull <= 1'b0;
        tick(5);
        scl <= 1'b1;
        tick(6);
        sda_pull <= 1'b1;
        tick(6);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic stop();
        tick(1);
        sda_pull <= 1'b1;
        tick(5);
        scl <= 1'b1;
        tick(6);
        sda_pull <= 1'b0;
        tick(6);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_slot(d[i], s);
        end
        bit_slot(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_slot(1'b1, d[i]);
        end
        bit_slot(nack, s);
    endtask
endmodule

// >>> verif/linear_hall_position_i2c_target_test.sv
`timescale 1ns/1ps
module linear_hall_position_i2c_target_test;
    localparam int SETTLE = 20;
    logic mclk;
    logic fe_clk;
    logic reset_n;
    logic adr;
    logic fe_valid;
    logic signed [15:0] fe_field;
    logic scl;
    logic host_pull;
    logic sda_out;
    logic sda_oe;
    logic fe_pd;
    logic fe_fast;
    logic [6:0] dev_addr;
    logic [7:0] rd;
    int n_mismatch;
    int n_checks;
    int rng[4] = '{500, 250, 125, 185};
    logic [1:0] t_code[6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    logic t_pol[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    int t_fld[6] = '{0, 100, 100, 1000, -37, -2000};
    // pull-up: low whenever either party pulls
    wire sda = ~(host_pull | (sda_oe & ~sda_out));
    hall_i2c_target #(.SETTLE_CYCLES(SETTLE)) hall_i2c_target_inst (
        .MCLK(mclk),
        .RESET_N(reset_n),
        .SCL_IN(scl),
        .SDA_IN(sda),
        .SDA_OUT(sda_out),
        .SDA_OE(sda_oe),
        .ADDRESS_JUMPER(adr),
        .FE_CLK(fe_clk),
        .FE_VALID(fe_valid),
        .FE_FIELD(fe_field),
        .FE_POWER_DOWN(fe_pd),
        .FE_FAST(fe_fast)
    );
    i2c_host_model i2c_host_model_inst (
        .clk(mclk),
        .sda(sda),
        .scl(scl),
        .sda_pull(host_pull)
    );
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial
    begin
        fe_clk = 1'b0;
        #7;
        forever #62.5 fe_clk = ~fe_clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic probe(input logic [6:0] a, input logic exp_ack);
        logic ack;
        i2c_host_model_inst.start();
        i2c_host_model_inst.wbyte({a, 1'b0}, ack);
        i2c_host_model_inst.stop();
        chk("address ack", {7'h00, ack}, {7'h00, exp_ack});
    endtask
    task automatic xfer_w(input logic [7:0] p, input logic [7:0] d);
        logic ack;
        i2c_host_model_inst.start();
        i2c_host_model_inst.wbyte({dev_addr, 1'b0}, ack);
        i2c_host_model_inst.wbyte(p, ack);
        i2c_host_model_inst.wbyte(d, ack);
        i2c_host_model_inst.stop();
        chk("write ack", {7'h00, ack}, 8'h01);
    endtask
    task automatic xfer_r(input logic [7:0] p, output logic [7:0] d);
        logic ack;
        i2c_host_model_inst.start();
        i2c_host_model_inst.wbyte({dev_addr, 1'b0}, ack);
        i2c_host_model_inst.wbyte(p, ack);
        i2c_host_model_inst.start();
        i2c_host_model_inst.wbyte({dev_addr, 1'b1}, ack);
        i2c_host_model_inst.rbyte(1'b1, d);
        i2c_host_model_inst.stop();
    endtask
    task automatic chk_pos(input int v);
        logic [9:0] e;
        logic fl;
        logic [7:0] d;
        fl = (v < 0) || (v > 1023);
        e = (v < 0) ? 10'h000 : ((v > 1023) ? 10'h3FF : 10'(v));
        xfer_r(hall_pkg::REG_POS_LO, d);
        chk("position low", d, e[7:0]);
        xfer_r(hall_pkg::REG_POS_HI, d);
        chk("position high", d, {4'h0, ^{fl, e}, fl, e[9:8]});
    endtask
    // the front end drops samples while busy, so leave room after each one
    task automatic fe_sample(input int f);
        @(posedge fe_clk);
        fe_valid <= 1'b1;
        fe_field <= 16'(f);
        @(posedge fe_clk);
        fe_valid <= 1'b0;
        repeat (40) @(posedge mclk);
    endtask
    initial
    begin
        #2ms;
        n_mismatch++;
        finish_test();
    end
    initial
    begin
        reset_n = 1'b0;
        adr = 1'b0;
        fe_valid = 1'b0;
        fe_field = 16'h0000;
        dev_addr = hall_pkg::ADDR_STRAP_LO;
        n_mismatch = 0;
        n_checks = 0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (SETTLE + 20) @(posedge mclk);
        probe(hall_pkg::ADDR_STRAP_HI, 1'b0);
        probe(hall_pkg::ADDR_STRAP_LO, 1'b1);
        chk_pos(511);
        xfer_r(hall_pkg::REG_CFG, rd);
        chk("config default", rd, hall_pkg::CFG_RESET);
        xfer_r(hall_pkg::REG_RANGE, rd);
        chk("range default", rd, 8'h00);
        xfer_r(8'h05, rd);
        chk("unmapped", rd, 8'h00);
        xfer_w(hall_pkg::REG_POS_LO, 8'h55);
        chk_pos(511);
        fe_sample(100);
        chk_pos((511 + 613) >> 1);
        xfer_w(hall_pkg::REG_CFG, 8'hFF);
        xfer_r(hall_pkg::REG_CFG, rd);
        chk("config mask", rd, 8'h0B);
        chk("power down", {7'h00, fe_pd}, 8'h01);
        chk("fast", {7'h00, fe_fast}, 8'h01);
        fe_sample(200);
        chk_pos(562);
        for (int i = 0; i < 6; i++)
        begin
            xfer_w(hall_pkg::REG_CFG, {4'h0, 1'b1, 1'b0, t_pol[i], 1'b0});
            xfer_w(hall_pkg::REG_RANGE, {6'h00, t_code[i]});
            xfer_r(hall_pkg::REG_RANGE, rd);
            chk("range", rd, {6'h00, t_code[i]});
            fe_sample(t_fld[i]);
            chk_pos((t_pol[i] ? -t_fld[i] : t_fld[i]) * 511 / rng[t_code[i]] + 511);
        end
        chk("power up", {7'h00, fe_pd}, 8'h00);
        adr <= 1'b1;
        repeat (10) @(posedge mclk);
        probe(hall_pkg::ADDR_STRAP_LO, 1'b0);
        probe(hall_pkg::ADDR_STRAP_HI, 1'b1);
        dev_addr = hall_pkg::ADDR_STRAP_HI;
        chk_pos(-1);
        finish_test();
    end
endmodule
